//--- rtl/fpec_ctrl.sv
// flash program/erase control: mode bits, erase block map, system control two
// assumes an apb master on I_MCLK and a write-permit pin synchronous to the clock
`timescale 1ns/1ps
`include "fpec_defines.svh"

// What this block does
// R1: program-verify bit 2 resets to 0, sets only while the permit pin and software enable are high, clears on 0.
// R2: erase bit 1 resets to 0, sets only with permit pin, software enable and erase setup high, clears on 0.
// R3: program bit 0 resets to 0, sets only with permit pin, software enable and program setup high, clears on 0.
// R4: software sets at most one of the mode control bits in any single write; the block does not check this and takes every bit of the write at once.
// R5: while the permit pin is low no program or erase reaches the flash, whatever the bits hold.
// R6: erase works on whole blocks and an erased byte reads as all ones.
// R7: twelve erase blocks: eight of 4 kbytes from zero, one of 32 kbytes from 008000, three of 64 kbytes to 03FFFF.
// R8: software erases blocks before programming them and never programs unerased blocks.
// R9: software confirms the permit pin is high before moving the control routine into ram.
// R10: system control two is 8 bits, holds a read/write flash select bit 3, clears on reset and standby.
// R11: bits 7 to 4 of system control two ignore writes and read as 0.
// R12: without flash, system control two ignores writes and reads an undefined value.
// R13: a refused set leaves the bit at 0 and no mode change happens.
module fpec_ctrl #(
    parameter bit FLASH_PRESENT = 1'b1
)
(
    // clock, reset, enable
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    input wire logic I_HW_STANDBY,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [19:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic [31:0] O_PRDATA,
    // flash side
    input wire logic I_FLASH_WRITE_PERMIT_PIN,
    input wire logic [17:0] I_FLASH_ADDR,
    output logic O_PROGRAM_MODE,
    output logic O_ERASE_MODE,
    output logic O_PROGRAM_VERIFY_MODE,
    output logic O_ERASE_VERIFY_MODE,
    output logic [11:0] O_ERASE_BLOCKS,
    output logic [7:0] O_ERASE_FILL,
    output logic [3:0] O_ADDR_BLOCK,
    output logic O_ADDR_VALID,
    output logic O_FLASH_CONTROL_SELECT
);

    // register state
    logic [6:0] mode;
    logic [11:0] blksel;
    logic [7:0] sysctl;
    fpec_pkg::fpec_phase_t phase;
    logic [31:0] rdata;
    logic slverr;
    logic [7:0] erase_fill;

    // decoded access
    logic [17:0] idx;
    logic hit_mode;
    logic hit_blk;
    logic hit_sys;
    logic hit_st;
    logic hit_any;
    logic access;
    logic wr_done;
    logic wr_mode;
    logic [7:0] wdat;
    logic software_write_enable_bit;
    logic permit;
    logic prog_act;
    logic erase_act;
    logic pvfy_act;
    logic [31:0] next_rdata;
    fpec_pkg::fpec_block_t next_block;

    // word index from the byte address
    assign idx = I_PADDR[19:2];
    assign hit_mode = (idx == {2'h0, `FPEC_IDX_MODE}) && (I_PADDR[1:0] == 2'h0);
    assign hit_blk = (idx == {2'h0, `FPEC_IDX_BLKSEL}) && (I_PADDR[1:0] == 2'h0);
    assign hit_sys = (idx == {2'h0, `FPEC_IDX_SYSCTL}) && (I_PADDR[1:0] == 2'h0);
    assign hit_st = (idx == {2'h0, `FPEC_IDX_STATUS}) && (I_PADDR[1:0] == 2'h0);
    assign hit_any = hit_mode | hit_blk | hit_sys | hit_st;
    assign access = I_PSEL & I_PENABLE;
    assign wr_done = I_CE & access & O_PREADY & I_PWRITE;
    // mode control only takes writes while flash select is set
    assign wr_mode = wr_done & hit_mode & sysctl[`FPEC_BIT_FSEL];
    assign wdat = I_PWDATA[7:0];
    assign software_write_enable_bit = mode[`FPEC_BIT_SWE];
    assign permit = I_FLASH_WRITE_PERMIT_PIN;

    // one wait state: answer on the second access cycle
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RST_B)
            phase <= fpec_pkg::FPEC_IDLE;
        else if (I_CE)
        begin
            unique case (phase)
                fpec_pkg::FPEC_IDLE: if (access) phase <= fpec_pkg::FPEC_WAIT;
                fpec_pkg::FPEC_WAIT: phase <= fpec_pkg::FPEC_IDLE;
            endcase
        end
    end
    assign O_PREADY = (phase == fpec_pkg::FPEC_WAIT);
    assign O_PSLVERR = slverr & O_PREADY;
    assign O_PRDATA = rdata;

    // read mux
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (hit_mode)
            next_rdata = {25'h0000000, mode};
        else if (hit_blk)
            next_rdata = {20'h00000, blksel};
        else if (hit_sys)
            next_rdata = {24'h000000, FLASH_PRESENT ? sysctl : `FPEC_UNDEF_READ}; // [R11] [R12]
        else if (hit_st)
            next_rdata = {28'h0000000, pvfy_act, erase_act, prog_act, permit};
    end

    // capture read data and error in the first access cycle
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RST_B)
        begin
            rdata <= 32'h0000_0000;
            slverr <= 1'b0;
        end
        else if (I_CE && access && phase == fpec_pkg::FPEC_IDLE)
        begin
            rdata <= I_PWRITE ? 32'h0000_0000 : next_rdata;
            slverr <= ~hit_any;
        end
    end

    // system control two: only the select bit is writable
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RST_B || I_HW_STANDBY)
            sysctl <= `FPEC_SYSCTL_RST; // [R10]
        else if (I_CE && wr_done && hit_sys && FLASH_PRESENT) // [R12]
            sysctl[`FPEC_BIT_FSEL] <= wdat[`FPEC_BIT_FSEL]; // [R10] [R11]
    end
    assign O_FLASH_CONTROL_SELECT = sysctl[`FPEC_BIT_FSEL];

    // mode control: plain bits store, gated bits need their condition to set
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RST_B || I_HW_STANDBY)
            mode <= `FPEC_MODE_RST; // [R1] [R2] [R3]
        else if (wr_mode)
        begin
            mode[`FPEC_BIT_SWE] <= wdat[`FPEC_BIT_SWE];
            mode[`FPEC_BIT_ESU] <= wdat[`FPEC_BIT_ESU];
            mode[`FPEC_BIT_PSU] <= wdat[`FPEC_BIT_PSU];
            mode[`FPEC_BIT_EVFY] <= wdat[`FPEC_BIT_EVFY];
            // refused sets leave the bit clear
            mode[`FPEC_BIT_PVFY] <= wdat[`FPEC_BIT_PVFY] & permit & software_write_enable_bit; // [R1] [R13]
            mode[`FPEC_BIT_ERASE] <= wdat[`FPEC_BIT_ERASE] & permit & software_write_enable_bit & mode[`FPEC_BIT_ESU]; // [R2] [R13]
            mode[`FPEC_BIT_PROG] <= wdat[`FPEC_BIT_PROG] & permit & software_write_enable_bit & mode[`FPEC_BIT_PSU]; // [R3] [R13]
        end
    end

    // erase block select
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RST_B || I_HW_STANDBY)
            blksel <= `FPEC_BLKSEL_RST;
        else if (I_CE && wr_done && hit_blk)
            blksel <= I_PWDATA[11:0];
    end

    // the permit pin overrides the stored program, erase and program-verify bits
    assign prog_act = mode[`FPEC_BIT_PROG] & permit; // [R5]
    assign erase_act = mode[`FPEC_BIT_ERASE] & permit; // [R5]
    assign pvfy_act = mode[`FPEC_BIT_PVFY] & permit; // [R5]
    assign O_PROGRAM_MODE = prog_act;
    assign O_ERASE_MODE = erase_act;
    assign O_PROGRAM_VERIFY_MODE = pvfy_act;
    assign O_ERASE_VERIFY_MODE = mode[`FPEC_BIT_EVFY];

    // whole-block erase strobes, one per block
    genvar b;
    generate
        for (b = 0; b < 12; b++)
        begin : g_blk
            assign O_ERASE_BLOCKS[b] = blksel[b] & erase_act; // [R6] [R5]
        end
    endgenerate

    // fill value written to every byte of an erased block
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RST_B)
            erase_fill <= 8'h00;
        else if (I_CE)
            erase_fill <= `FPEC_ERASE_FILL; // [R6]
    end
    assign O_ERASE_FILL = erase_fill;

    // address to erase block decode
    always_comb
    begin
        if (I_FLASH_ADDR < `FPEC_SMALL_END)
            next_block = {1'b0, I_FLASH_ADDR[14:12]}; // [R7]
        else if (I_FLASH_ADDR < `FPEC_MID_END)
            next_block = `FPEC_MID_BLOCK; // [R7]
        else
            next_block = `FPEC_LARGE_BASE + {2'h0, I_FLASH_ADDR[17:16]}; // [R7]
    end
    assign O_ADDR_BLOCK = next_block;
    assign O_ADDR_VALID = 1'b1; // 18-bit address never leaves 000000..03FFFF

    // assertions
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);

    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence s_access;
        I_PSEL && I_PENABLE;
    endsequence

    a_pv_refused: assert property (wr_mode && wdat[2] && !(permit && software_write_enable_bit) |=> !mode[2]) // [R1]
        else $error("program-verify set without permit and enable");
    a_pv_taken: assert property (wr_mode && wdat[2] && permit && software_write_enable_bit && !I_HW_STANDBY |=> mode[2]) // [R1]
        else $error("program-verify not entered");
    a_erase_refused: assert property (wr_mode && wdat[1] && !(permit && software_write_enable_bit && mode[5]) |=> !mode[1]) // [R2]
        else $error("erase set without its condition");
    a_prog_refused: assert property (wr_mode && wdat[0] && !(permit && software_write_enable_bit && mode[4]) |=> !mode[0]) // [R3]
        else $error("program set without its condition");
    a_hw_protect: assert property (!permit |-> !O_PROGRAM_MODE && !O_ERASE_MODE && O_ERASE_BLOCKS == 12'h000) // [R5]
        else $error("flash mode active with permit pin low");
    a_standby_clear: assert property (I_HW_STANDBY |=> sysctl == 8'h00 && mode == 7'h00) // [R10]
        else $error("standby did not clear control registers");
    a_sys_reserved: assert property (O_PREADY && hit_sys && !I_PWRITE |-> O_PRDATA[31:4] == 28'h0) // [R11]
        else $error("reserved bits read nonzero");
    a_block_mid: assert property (I_FLASH_ADDR >= 18'h08000 && I_FLASH_ADDR < 18'h10000 |-> O_ADDR_BLOCK == 4'h8) // [R7]
        else $error("32 kbyte block decode wrong");
    a_block_top: assert property (I_FLASH_ADDR >= 18'h30000 |-> O_ADDR_BLOCK == 4'hB) // [R7]
        else $error("last 64 kbyte block decode wrong");
    a_apb_wait: assert property ((s_setup and I_CE) ##1 (s_access and I_CE) |=> O_PREADY) // apb answer
        else $error("apb answer not on second access cycle");

endmodule : fpec_ctrl

//--- rtl/fpec_defines.svh
// constants for the flash program/erase control block
// assumes a 32-bit apb slave with one register per aligned word
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH

// register indexes, byte address is four times the index
`define FPEC_IDX_MODE 16'hFF40
`define FPEC_IDX_BLKSEL 16'hFF41
`define FPEC_IDX_SYSCTL 16'hFF42
`define FPEC_IDX_STATUS 16'hFF43

// mode control register fields
`define FPEC_BIT_PROG 0
`define FPEC_BIT_ERASE 1
`define FPEC_BIT_PVFY 2
`define FPEC_BIT_EVFY 3
`define FPEC_BIT_PSU 4
`define FPEC_BIT_ESU 5
`define FPEC_BIT_SWE 6

// system control two fields
`define FPEC_BIT_FSEL 3

// status register fields
`define FPEC_BIT_ST_PIN 0
`define FPEC_BIT_ST_PROG 1
`define FPEC_BIT_ST_ERASE 2
`define FPEC_BIT_ST_PVFY 3

// reset values
`define FPEC_MODE_RST 7'h00
`define FPEC_SYSCTL_RST 8'h00
`define FPEC_BLKSEL_RST 12'h000
`define FPEC_UNDEF_READ 8'h00

// erased byte value
`define FPEC_ERASE_FILL 8'hFF

// erase block map limits
`define FPEC_SMALL_END 18'h08000
`define FPEC_MID_END 18'h10000
`define FPEC_MID_BLOCK 4'h8
`define FPEC_LARGE_BASE 4'h8

`endif

//--- rtl/fpec_pkg.sv
// types for the flash program/erase control block
// assumes fpec_defines.svh supplies the numeric constants
package fpec_pkg;

    // index of one of the twelve erase blocks
    typedef logic [3:0] fpec_block_t;

    // one bit per erase block
    typedef logic [11:0] fpec_blkmask_t;

    // apb access phase of the slave
    typedef enum logic [0:0]
    {
        FPEC_IDLE = 1'b0,
        FPEC_WAIT = 1'b1
    } fpec_phase_t;

endpackage : fpec_pkg

//--- sim/fpec_tb.sv
// self-checking bench for the flash program/erase control block
// assumes fpec_ctrl with FLASH_PRESENT=1, apb at byte address four times the register index
`timescale 1ns/1ps
`include "fpec_defines.svh"
module testbench;
    localparam logic [19:0] A_MODE = 20'({`FPEC_IDX_MODE, 2'b00});
    localparam logic [19:0] A_BLK = 20'({`FPEC_IDX_BLKSEL, 2'b00});
    localparam logic [19:0] A_SYS = 20'({`FPEC_IDX_SYSCTL, 2'b00});
    localparam logic [19:0] A_STAT = 20'({`FPEC_IDX_STATUS, 2'b00});
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sby = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic pin = 1'b0;
    logic [19:0] paddr = 20'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [17:0] faddr = 18'h00000;
    logic pready, pslverr, pm, em, pvm, evm, avalid, fsel;
    logic [31:0] prdata;
    logic [11:0] eblk;
    logic [7:0] efill;
    logic [3:0] ablk;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] lfsr = 32'h00015983;
    logic [33:0] notes[$];
    logic [17:0] base, size;
    logic ce = 1'b1;
    logic nf_fsel;
    logic [31:0] nf_prdata;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    fpec_ctrl u_dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_HW_STANDBY(sby), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_PRDATA(prdata), .I_FLASH_WRITE_PERMIT_PIN(pin), .I_FLASH_ADDR(faddr),
        .O_PROGRAM_MODE(pm), .O_ERASE_MODE(em), .O_PROGRAM_VERIFY_MODE(pvm), .O_ERASE_VERIFY_MODE(evm),
        .O_ERASE_BLOCKS(eblk), .O_ERASE_FILL(efill), .O_ADDR_BLOCK(ablk), .O_ADDR_VALID(avalid),
        .O_FLASH_CONTROL_SELECT(fsel));

    // variant without flash on the same bus; only its read data and select bit are watched
    fpec_ctrl #(.FLASH_PRESENT(1'b0)) u_dut_noflash (.I_MCLK(clk), .I_RST_B(rst_b), .I_CE(ce),
        .I_HW_STANDBY(sby), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PREADY(), .O_PSLVERR(), .O_PRDATA(nf_prdata),
        .I_FLASH_WRITE_PERMIT_PIN(pin), .I_FLASH_ADDR(faddr), .O_PROGRAM_MODE(), .O_ERASE_MODE(),
        .O_PROGRAM_VERIFY_MODE(), .O_ERASE_VERIFY_MODE(), .O_ERASE_BLOCKS(), .O_ERASE_FILL(),
        .O_ADDR_BLOCK(), .O_ADDR_VALID(), .O_FLASH_CONTROL_SELECT(nf_fsel));

    // pseudo-random source for flash addresses
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    // compare one value and count it
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask : check

    // one apb transfer; the expected answer is queued for the monitor
    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d, input logic [31:0] exp,
        input logic err);
        @(posedge clk);
        notes.push_back({wr, err, exp});
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // hold the request until pready is seen high at a rising edge; only the watchdog ends a hung wait
        do
            @(posedge clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h00000000, 1'b0);
    endtask : wr

    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000, exp, 1'b0);
    endtask : rd

    // program, erase and program-verify outputs as one word
    task automatic modes(input logic [2:0] exp);
        @(negedge clk);
        check("mode outputs", {29'h0, pvm, em, pm}, {29'h0, exp});
        @(posedge clk);
    endtask : modes

    // monitor: takes the oldest note when a transfer completes
    always @(negedge clk)
        if (psel && pen && pready === 1'b1)
        begin
            check("pslverr", {31'h0, pslverr}, {31'h0, notes[0][32]});
            if (!notes[0][33])
                check("prdata", prdata, notes[0][31:0]);
            void'(notes.pop_front());
        end

    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // watchdog against a hung handshake
    initial
    begin
        repeat (6000) @(posedge clk);
        err_total++;
        results();
    end

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(A_MODE, 32'h00000000);
        rd(A_SYS, 32'h00000000);
        modes(3'h0);
        $display("test reset done");
        pin <= 1'b1;
        rd(A_STAT, 32'h00000001);
        wr(A_MODE, 32'h00000040);
        rd(A_MODE, 32'h00000000);
        wr(A_SYS, 32'h000000FF);
        rd(A_SYS, 32'h00000008);
        check("select bit", {31'h0, fsel}, 32'h00000001);
        check("no-flash select", {31'h0, nf_fsel}, 32'h00000000);
        check("no-flash read", nf_prdata, {24'h0, `FPEC_UNDEF_READ});
        $display("test system control done");
        wr(A_MODE, 32'h00000040);
        wr(A_MODE, 32'h00000042);
        rd(A_MODE, 32'h00000040);
        wr(A_BLK, 32'h00000A55);
        wr(A_MODE, 32'h00000060);
        wr(A_MODE, 32'h00000062);
        modes(3'h2);
        check("erase blocks", {20'h0, eblk}, 32'h00000A55);
        check("erase fill", {24'h0, efill}, {24'h0, `FPEC_ERASE_FILL});
        wr(A_MODE, 32'h00000060);
        modes(3'h0);
        check("erase blocks off", {20'h0, eblk}, 32'h00000000);
        $display("test erase done");
        pin <= 1'b0;
        wr(A_MODE, 32'h00000040);
        wr(A_MODE, 32'h00000050);
        wr(A_MODE, 32'h00000051);
        rd(A_MODE, 32'h00000050);
        modes(3'h0);
        pin <= 1'b1;
        wr(A_MODE, 32'h00000051);
        rd(A_MODE, 32'h00000051);
        rd(A_STAT, 32'h00000003);
        modes(3'h1);
        pin <= 1'b0;
        modes(3'h0);
        pin <= 1'b1;
        wr(A_MODE, 32'h00000050);
        modes(3'h0);
        $display("test program done");
        wr(A_MODE, 32'h00000000);
        wr(A_MODE, 32'h00000004);
        rd(A_MODE, 32'h00000000);
        wr(A_MODE, 32'h00000040);
        wr(A_MODE, 32'h00000044);
        modes(3'h4);
        wr(A_MODE, 32'h00000040);
        modes(3'h0);
        wr(A_MODE, 32'h00000048);
        @(negedge clk);
        check("erase verify", {31'h0, evm}, 32'h00000001);
        wr(A_MODE, 32'h00000040);
        @(negedge clk);
        check("erase verify off", {31'h0, evm}, 32'h00000000);
        $display("test verify done");
        apb(1'b0, A_STAT + 20'h00004, 32'h00000000, 32'h00000000, 1'b1);
        apb(1'b0, A_MODE + 20'h00001, 32'h00000000, 32'h00000000, 1'b1);
        apb(1'b1, A_STAT + 20'h00004, 32'h000000FF, 32'h00000000, 1'b1);
        $display("test unmapped done");
        for (int i = 0; i < 12; i++)
            for (int k = 0; k < 3; k++)
            begin
                base = (i < 8) ? 18'(i * 32'h00001000) : (i == 8) ? 18'h08000 : 18'((i - 8) * 32'h00010000);
                size = (i < 8) ? 18'h01000 : (i == 8) ? 18'h08000 : 18'h10000;
                @(posedge clk);
                faddr <= (k == 0) ? base : (k == 1) ? base + size - 18'h00001 : base + 18'(rnd() % size);
                @(negedge clk);
                check("address block", {28'h0, ablk}, i);
                check("address valid", {31'h0, avalid}, 32'h00000001);
            end
        $display("test block map done");
        // clock enable low: a transfer started now must stall until it returns
        @(posedge clk);
        ce <= 1'b0;
        fork
            wr(A_BLK, 32'h00000123);
            begin
                repeat (4)
                begin
                    @(negedge clk);
                    check("ready frozen", {31'h0, pready}, 32'h00000000);
                end
                @(posedge clk);
                ce <= 1'b1;
            end
        join
        rd(A_BLK, 32'h00000123);
        $display("test clock enable done");
        @(posedge clk);
        sby <= 1'b1;
        @(posedge clk);
        sby <= 1'b0;
        rd(A_SYS, 32'h00000000);
        rd(A_MODE, 32'h00000000);
        rd(A_BLK, 32'h00000000);
        $display("test standby done");
        check("notes left", notes.size(), 32'h00000000);
        results();
    end
endmodule : testbench
